/* File: flash_ctrl_write_guard.sv */
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - lock disable needs 0 then 1, rewrite on
// - flash reset acts only in rewrite mode
// - power off bit 1 cuts flash supply
// - power off needs 0 then 1 writes
// - parallel I/O mode ignores power off bit
// - commands accepted only in rewrite mode
module flash_ctrl_write_guard
  import flash_guard_pkg::*;
(
  input  wire logic        i_ref_clk,         // system clock, 200 MHz
  input  wire logic        i_arst_n,          // async reset, active low
  input  wire logic [3:0]  i_avs_address,     // byte address
  input  wire logic        i_avs_read,        // read request
  input  wire logic        i_avs_write,       // write request
  input  wire logic [31:0] i_avs_writedata,   // write data
  input  wire logic [3:0]  i_avs_byteenable,  // byte lanes
  output logic [31:0]      o_avs_readdata,    // read data, registered
  output logic             o_avs_waitrequest, // stall
  input  wire logic        i_par_io_pin,      // parallel I/O mode pin, async
  input  wire logic        i_cmd_valid,       // software command strobe
  output logic             o_cmd_accept,      // command passed to flash
  output logic             o_flash_reset,     // flash reset request
  output logic             o_flash_power_on,  // flash supply enable
  output flash_ctrl_s      o_ctrl             // control bits
);

  flash_ctrl_s ctrl_r, ctrl_nxt;
  logic        arm_lock_r, arm_lock_nxt;
  logic        arm_pwr_r, arm_pwr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        ack_r, ack_nxt;
  logic [2:0]  par_sync_r;
  logic        par_mode_r, par_mode_nxt;

  logic        req;
  logic        commit;
  logic        wr0, wr1;
  logic [7:0]  wd;
  logic [7:0]  ctrl0_view, ctrl1_view;

  assign req    = (i_avs_read | i_avs_write) & ~ack_r;
  // a write lands only on the edge where the master sees waitrequest low
  assign commit = i_avs_write & ack_r;
  assign wd     = i_avs_writedata[7:0];
  assign wr0    = commit & i_avs_byteenable[0] & (i_avs_address == CTRL0_OFFSET);
  assign wr1    = commit & i_avs_byteenable[0] & (i_avs_address == CTRL1_OFFSET);

  assign ctrl0_view = {2'b00, ctrl_r.user_rom_area_select, 1'b0, ctrl_r.flash_reset_bit,
                       ctrl_r.lock_disable_bit, ctrl_r.rewrite_mode_select, 1'b0};
  assign ctrl1_view = {4'h0, ctrl_r.flash_power_off_bit, 3'b000};

  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    arm_lock_nxt = arm_lock_r;
    arm_pwr_nxt  = arm_pwr_r;
    // reserved bits are never stored, whatever software writes
    if (wr0)
    begin
      ctrl_nxt.rewrite_mode_select  = wd[REWRITE_SEL_BIT];
      ctrl_nxt.flash_reset_bit      = wd[FRESET_BIT];
      ctrl_nxt.user_rom_area_select = wd[UROM_SEL_BIT];
      if (!wd[LOCK_DIS_BIT])
        ctrl_nxt.lock_disable_bit = 1'b0;
      else if (arm_lock_r && ctrl_r.rewrite_mode_select)
        ctrl_nxt.lock_disable_bit = 1'b1;
      arm_lock_nxt = ~wd[LOCK_DIS_BIT];
    end
    // a write to the other register breaks the lock sequence
    else if (wr1)
      arm_lock_nxt = 1'b0;
    if (wr1)
    begin
      if (!wd[PWR_OFF_BIT])
        ctrl_nxt.flash_power_off_bit = 1'b0;
      else if (arm_pwr_r)
        ctrl_nxt.flash_power_off_bit = 1'b1;
      arm_pwr_nxt = ~wd[PWR_OFF_BIT];
    end
    else if (wr0)
      arm_pwr_nxt = 1'b0;
    // lock disable only stands while rewrite mode is selected
    if (!ctrl_nxt.rewrite_mode_select)
      ctrl_nxt.lock_disable_bit = 1'b0;
  end

  always_comb
  begin
    ack_nxt   = req;
    rdata_nxt = 32'h0000_0000;
    if (req && i_avs_read)
    begin
      unique case (i_avs_address)
        CTRL0_OFFSET: rdata_nxt = {24'h00_0000, ctrl0_view};
        CTRL1_OFFSET: rdata_nxt = {24'h00_0000, ctrl1_view};
        MODE_OFFSET:  rdata_nxt = {31'h0000_0000, par_mode_r};
        default:      rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // parallel I/O pin: change accepted when stages two and three agree
  always_comb
  begin
    par_mode_nxt = par_mode_r;
    if (par_sync_r[1] == par_sync_r[2])
      par_mode_nxt = par_sync_r[2];
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl_r     <= '0;
      arm_lock_r <= 1'b0;
      arm_pwr_r  <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      ack_r      <= 1'b0;
      par_sync_r <= 3'h0;
      par_mode_r <= 1'b0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      arm_lock_r <= arm_lock_nxt;
      arm_pwr_r  <= arm_pwr_nxt;
      rdata_r    <= rdata_nxt;
      ack_r      <= ack_nxt;
      par_sync_r <= {par_sync_r[1:0], i_par_io_pin};
      par_mode_r <= par_mode_nxt;
    end
  end

  // one wait cycle per access, answer on the second edge
  assign o_avs_waitrequest = ~ack_r;
  assign o_avs_readdata    = rdata_r;
  assign o_ctrl            = ctrl_r;

  assign o_flash_reset = ctrl_r.flash_reset_bit & ctrl_r.rewrite_mode_select;

  assign o_flash_power_on = par_mode_r | ~ctrl_r.flash_power_off_bit;

  assign o_cmd_accept = i_cmd_valid & ctrl_r.rewrite_mode_select & ~par_mode_r;

  a_lock_needs_arm: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(ctrl_r.lock_disable_bit) |-> $past(arm_lock_r) && $past(wr0))
    else $error("lock disable set without unlock");
  a_lock_needs_mode: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    ctrl_r.lock_disable_bit |-> ctrl_r.rewrite_mode_select)
    else $error("lock disable set outside rewrite mode");
  a_pwr_needs_arm: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(ctrl_r.flash_power_off_bit) |-> $past(arm_pwr_r) && $past(wr1))
    else $error("power off set without unlock");
  a_pwr_seq_sets: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    wr1 && arm_pwr_r && wd[PWR_OFF_BIT] |=> ctrl_r.flash_power_off_bit)
    else $error("unlock sequence did not set power off");
  a_arm_dropped: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    wr0 |=> !arm_pwr_r)
    else $error("power unlock survived other write");
  a_reset_gated: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_flash_reset |-> ctrl_r.rewrite_mode_select && ctrl_r.flash_reset_bit)
    else $error("flash reset outside rewrite mode");
  a_supply_off: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    ctrl_r.flash_power_off_bit && !par_mode_r |-> !o_flash_power_on)
    else $error("supply not cut");
  a_par_override: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    par_mode_r |-> o_flash_power_on && !o_cmd_accept)
    else $error("parallel mode not overriding");
  a_cmd_gate: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_cmd_accept |-> ctrl_r.rewrite_mode_select)
    else $error("command accepted in normal mode");
  a_bus_answer: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    req |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer timing wrong");

  // unlock sequences, command gate and bus data checks
  a_lock_seq_sets: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    wr0 && arm_lock_r && ctrl_r.rewrite_mode_select
      && wd[LOCK_DIS_BIT] && wd[REWRITE_SEL_BIT] |=> ctrl_r.lock_disable_bit)
    else $error("unlock sequence did not set lock disable");
  a_lock_lone_held: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    wr0 && !arm_lock_r && !ctrl_r.lock_disable_bit |=> !ctrl_r.lock_disable_bit)
    else $error("lone write set lock disable");
  a_pwr_lone_held: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    wr1 && !arm_pwr_r && !ctrl_r.flash_power_off_bit |=> !ctrl_r.flash_power_off_bit)
    else $error("lone write set power off");
  a_lock_arm_dropped: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    wr1 |=> !arm_lock_r)
    else $error("lock unlock survived other write");
  a_cmd_open: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    i_cmd_valid && ctrl_r.rewrite_mode_select && !par_mode_r |-> o_cmd_accept)
    else $error("command refused in rewrite mode");
  a_write_on_answer: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    wr0 || wr1 |-> !o_avs_waitrequest)
    else $error("write landed while stalled");
  a_upper_zero: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h00_0000)
    else $error("read data above byte zero");

  c_lock_set: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(ctrl_r.lock_disable_bit));
  c_pwr_off: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(ctrl_r.flash_power_off_bit));
  c_flash_reset: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_flash_reset));
  c_par_mode: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(par_mode_r));
  c_cmd_accept: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_cmd_accept));

endmodule

/* File: flash_ctrl_write_guard_bench.sv */
`timescale 1ns/1ps
module flash_ctrl_write_guard_bench;
  import flash_guard_pkg::*;
  logic i_ref_clk = 1'b0, i_arst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic o_avs_waitrequest, i_par_io_pin = 1'b0, i_cmd_valid = 1'b0;
  logic o_cmd_accept, o_flash_reset, o_flash_power_on;
  flash_ctrl_s o_ctrl;
  int num_errors = 0, tests_run = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  flash_ctrl_write_guard DUT (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_par_io_pin(i_par_io_pin), .i_cmd_valid(i_cmd_valid), .o_cmd_accept(o_cmd_accept),
    .o_flash_reset(o_flash_reset), .o_flash_power_on(o_flash_power_on), .o_ctrl(o_ctrl));
  task automatic tally_and_finish();
    $display("errors %0d of %0d compares", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
    i_avs_write <= 1'b1;
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= be;
    @(posedge i_ref_clk iff o_avs_waitrequest === 1'b0);
    i_avs_write <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    i_avs_read <= 1'b1;
    i_avs_address <= a;
    @(posedge i_ref_clk iff o_avs_waitrequest === 1'b0);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    @(posedge i_ref_clk);
    chk(rd, exp);
  endtask
  initial
  begin
    #(5 * 4000);
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (5) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    @(posedge i_ref_clk);
    rdchk(CTRL0_OFFSET, 32'h0);
    rdchk(CTRL1_OFFSET, 32'h0);
    chk(o_flash_power_on, 32'h1);
    // lone set of power off is refused
    wr(CTRL1_OFFSET, 8'h08);
    rdchk(CTRL1_OFFSET, 32'h0);
    wr(CTRL1_OFFSET, 8'h00);
    wr(CTRL1_OFFSET, 8'h08);
    rdchk(CTRL1_OFFSET, 32'h8);
    chk(o_flash_power_on, 32'h0);
    // parallel mode overrides the power off bit
    i_par_io_pin <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk(o_flash_power_on, 32'h1);
    rdchk(MODE_OFFSET, 32'h1);
    i_par_io_pin <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    chk(o_flash_power_on, 32'h0);
    i_cmd_valid <= 1'b1;
    wr(CTRL0_OFFSET, 8'h08);
    chk(o_cmd_accept, 32'h0);
    chk(o_flash_reset, 32'h0);
    wr(CTRL0_OFFSET, 8'h0a);
    chk(o_flash_reset, 32'h1);
    chk(o_cmd_accept, 32'h1);
    wr(CTRL0_OFFSET, 8'h02);
    chk(o_flash_reset, 32'h0);
    // arm, then a write elsewhere disarms
    wr(CTRL1_OFFSET, 8'h08);
    wr(CTRL0_OFFSET, 8'h06);
    rdchk(CTRL0_OFFSET, 32'h2);
    wr(CTRL0_OFFSET, 8'h02);
    wr(CTRL0_OFFSET, 8'h06);
    rdchk(CTRL0_OFFSET, 32'h6);
    chk(o_ctrl.lock_disable_bit, 32'h1);
    // reserved positions read back as zero
    wr(CTRL0_OFFSET, 8'hd2);
    rdchk(CTRL0_OFFSET, 32'h2);
    wr(CTRL1_OFFSET, 8'hf7);
    rdchk(CTRL1_OFFSET, 32'h0);
    wr(CTRL0_OFFSET, 8'h00, 4'he);
    rdchk(CTRL0_OFFSET, 32'h2);
    // user area select is a plain stored bit
    wr(CTRL0_OFFSET, 8'h20);
    rdchk(CTRL0_OFFSET, 32'h20);
    chk(o_ctrl.user_rom_area_select, 32'h1);
    rdchk(4'hc, 32'h0);
    // lock disable refused outside rewrite mode
    wr(CTRL0_OFFSET, 8'h00);
    wr(CTRL0_OFFSET, 8'h04);
    rdchk(CTRL0_OFFSET, 32'h0);
    // mid-run reset reconnects the supply and clears the bit
    wr(CTRL1_OFFSET, 8'h00);
    wr(CTRL1_OFFSET, 8'h08);
    chk(o_flash_power_on, 32'h0);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk(o_flash_power_on, 32'h1);
    i_arst_n <= 1'b1;
    @(posedge i_ref_clk);
    wr(CTRL1_OFFSET, 8'h08);
    rdchk(CTRL1_OFFSET, 32'h0);
    i_cmd_valid <= 1'b0;
    tally_and_finish();
  end
endmodule

/* File: flash_guard_pkg.sv */
package flash_guard_pkg;

  // register word addresses (byte offsets, one aligned word each)
  localparam logic [3:0] CTRL0_OFFSET      = 4'h0;
  localparam logic [3:0] CTRL1_OFFSET      = 4'h4;
  localparam logic [3:0] MODE_OFFSET       = 4'h8;

  // control register zero fields
  localparam int         REWRITE_SEL_BIT   = 1;
  localparam int         LOCK_DIS_BIT      = 2;
  localparam int         FRESET_BIT        = 3;
  localparam int         UROM_SEL_BIT      = 5;
  // control register one fields
  localparam int         PWR_OFF_BIT       = 3;
  // mode register fields
  localparam int         PAR_IO_BIT        = 0;

  localparam logic [7:0] CTRL0_RESET       = 8'h00;
  localparam logic [7:0] CTRL1_RESET       = 8'h00;
  localparam logic [7:0] CTRL0_WMASK       = 8'h2e;
  localparam logic [7:0] CTRL1_WMASK       = 8'h08;

  typedef struct packed {
    logic rewrite_mode_select;
    logic lock_disable_bit;
    logic flash_reset_bit;
    logic user_rom_area_select;
    logic flash_power_off_bit;
  } flash_ctrl_s;

endpackage
